//--- rtl/ctmc_pkg.sv
`default_nettype none
package ctmc_pkg;
    // Transceiver mode bits {mode_bit_high, low}
    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_WAKE = 2'h1;
    localparam logic [1:0] MODE_RXO  = 2'h2;
    localparam logic [1:0] MODE_NORM = 2'h3;
    // Chip modes
    localparam logic [2:0] CHIP_NORMAL   = 3'h0;
    localparam logic [2:0] CHIP_STOP     = 3'h1;
    localparam logic [2:0] CHIP_SLEEP    = 3'h2;
    localparam logic [2:0] CHIP_RESTART  = 3'h3;
    localparam logic [2:0] CHIP_FAILSAFE = 3'h4;
    // Termination selection
    localparam logic [1:0] TERM_FLOAT = 2'h0;
    localparam logic [1:0] TERM_HALF  = 2'h1;
    localparam logic [1:0] TERM_GND   = 2'h2;
    localparam logic [1:0] TERM_2V5   = 2'h3;
    // Clock and times in ns
    localparam int CLK_NS           = 100;
    localparam int ENABLE_DELAY_NS  = 10000;
    localparam int WAKE_MIN_NS      = 500;
    localparam int WAKE_MAX_NS      = 1800000;
    localparam int SILENCE_NS       = 1000000;
    localparam int TX_TIMEOUT_NS    = 2700000;
    localparam int BUS_DOM_NS       = 2800000;
    // Least times round up, the wake maximum rounds down
    localparam int ENABLE_CYC = (ENABLE_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_MAX_CYC = WAKE_MAX_NS / CLK_NS;
    localparam int SILENCE_CYC = (SILENCE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TX_TO_CYC = (TX_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUS_TO_CYC = (BUS_DOM_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;
endpackage
`default_nettype wire

//--- rtl/ctmc_core.sv
`default_nettype none
// Overview of operation
// - Reset into Off; Off ignores wake-ups
// - Normal only by command in chip Normal
// - Normal: driver follows transmit input
// - Early dominant suppressed until recessive again
// - Receiver mirrors bus while reception active
// - Receive Only: no driver, chip Normal/Stop
// - Wake Capable by command; forced in Fail-Safe
// - Wake holds receive output low until change
// - Wake pattern: dominant, recessive, dominant windows
// - Mode reads Wake Capable; no rewake until rearmed
// - Rearm on chip Stop, Sleep, Fail-Safe entry
// - Stop/Normal wake: interrupt, status, stay
// - Stop wake enables watchdog if configured
// - Sleep/Fail-Safe wake: restart request, status, stay
// - Termination chosen by mode and state
// - Ground termination after silence time
// - Transmit timeout forces recessive, sets fail
// - Long bus dominant sets fail flag in Normal and Receive Only
// - Undervoltage sets flag, disables transmitter
// - Undervoltage monitored only when high bit set
module ctmc_core #(
    parameter int TX_TO_CYCLES  = ctmc_pkg::TX_TO_CYC,
    parameter int BUS_TO_CYCLES = ctmc_pkg::BUS_TO_CYC,
    parameter int SILENCE_CYCLES = ctmc_pkg::SILENCE_CYC,
    parameter int WAKE_MAX_CYCLES = ctmc_pkg::WAKE_MAX_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Mode command, chip mode, watchdog setup and flag clears
    input  wire logic       mode_wr,
    input  wire logic [1:0] mode_req,
    input  wire logic [2:0] chip_mode,
    input  wire logic       watchdog_on_bus_wake,
    input  wire logic       watchdog_enabled,
    input  wire logic       fail_clr,
    input  wire logic       uv_clr,
    input  wire logic       wake_clr,
    // Pins and analog comparators
    input  wire logic       tx_data_in,
    input  wire logic       bus_rx,
    input  wire logic       supply_uv,
    // Outputs
    output logic            bus_drive_dom,
    output logic            rx_data_out,
    output logic            interrupt_out_n,
    output logic [1:0]      mode_bits,
    output logic [1:0]      term_sel,
    output logic            wake_status_reg,
    output logic            transceiver_fail_flag,
    output logic            supply_undervoltage_flag,
    output logic            watchdog_enable_req,
    output logic            chip_restart_req
);
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        WK_IDLE = 4'h1, WK_DOM1 = 4'h2, WK_REC = 4'h4, WK_DOM2 = 4'h8
    } ctmc_wk_e;

    typedef struct packed {
        logic [1:0]                 tx_s;
        logic [1:0]                 rx_s;
        logic [1:0]                 uv_s;
        logic [1:0]                 mode;
        logic [2:0]                 chip_q;
        logic                       woken;
        logic                       armed;
        logic                       tx_block;
        logic [ctmc_pkg::CNT_W-1:0] en_cnt;
        logic [ctmc_pkg::CNT_W-1:0] tx_cnt;
        logic [ctmc_pkg::CNT_W-1:0] bus_cnt;
        logic [ctmc_pkg::CNT_W-1:0] wk_cnt;
        logic [ctmc_pkg::CNT_W-1:0] sil_cnt;
        ctmc_wk_e                   wk;
        logic                       drive;
        logic                       rxo;
        logic                       irq_n;
        logic [1:0]                 term;
        logic                       wstat;
        logic                       fail;
        logic                       uvf;
        logic                       wd_req;
        logic                       rst_req;
    } ctmc_st_s;

    localparam logic [ctmc_pkg::CNT_W-1:0] C_EN  =
        ctmc_pkg::CNT_W'(ctmc_pkg::ENABLE_CYC);
    localparam logic [ctmc_pkg::CNT_W-1:0] C_WMN =
        ctmc_pkg::CNT_W'(ctmc_pkg::WAKE_MIN_CYC);
    localparam logic [ctmc_pkg::CNT_W-1:0] C_WMX =
        ctmc_pkg::CNT_W'(WAKE_MAX_CYCLES);
    localparam logic [ctmc_pkg::CNT_W-1:0] C_SIL =
        ctmc_pkg::CNT_W'(SILENCE_CYCLES);
    localparam logic [ctmc_pkg::CNT_W-1:0] C_TXT =
        ctmc_pkg::CNT_W'(TX_TO_CYCLES);
    localparam logic [ctmc_pkg::CNT_W-1:0] C_BST =
        ctmc_pkg::CNT_W'(BUS_TO_CYCLES);
    localparam logic [ctmc_pkg::CNT_W-1:0] C_ONE = 16'h0001;
    localparam logic [ctmc_pkg::CNT_W-1:0] C_ZERO = 16'h0000;

    ctmc_st_s st;
    ctmc_st_s next_st;

    logic tx_i;
    logic rx_i;
    logic uv_i;
    logic chip_entry;
    logic rearm_chip;
    logic wake_ev;
    logic uv_on;
    logic cmd_ok;
    assign tx_i = st.tx_s[1];
    assign rx_i = st.rx_s[1];
    assign uv_i = st.uv_s[1];

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        next_st.tx_s = {st.tx_s[0], tx_data_in};
        next_st.rx_s = {st.rx_s[0], bus_rx};
        next_st.uv_s = {st.uv_s[0], supply_uv};
        next_st.chip_q = chip_mode;
        next_st.wd_req = 1'b0;
        next_st.rst_req = 1'b0;
        chip_entry = chip_mode != st.chip_q;
        rearm_chip = chip_entry && (chip_mode == ctmc_pkg::CHIP_STOP
            || chip_mode == ctmc_pkg::CHIP_SLEEP
            || chip_mode == ctmc_pkg::CHIP_FAILSAFE);
        wake_ev = 1'b0;
        uv_on = st.mode[1];
        // Command legality per chip mode
        cmd_ok = 1'b0;
        unique case (mode_req)
            ctmc_pkg::MODE_OFF:  cmd_ok = 1'b1;
            ctmc_pkg::MODE_NORM:
                cmd_ok = chip_mode == ctmc_pkg::CHIP_NORMAL;
            ctmc_pkg::MODE_RXO:
                cmd_ok = chip_mode == ctmc_pkg::CHIP_NORMAL
                    || chip_mode == ctmc_pkg::CHIP_STOP;
            ctmc_pkg::MODE_WAKE:
                cmd_ok = chip_mode != ctmc_pkg::CHIP_FAILSAFE;
        endcase
        if (chip_mode == ctmc_pkg::CHIP_FAILSAFE
            && st.mode != ctmc_pkg::MODE_WAKE)
        begin
            next_st.mode = ctmc_pkg::MODE_WAKE;
            next_st.armed = 1'b1;
            next_st.woken = 1'b0;
            next_st.sil_cnt = C_ZERO;
        end
        else if (mode_wr && cmd_ok && mode_req != st.mode)
        begin
            next_st.mode = mode_req;
            next_st.woken = 1'b0;
            next_st.armed = mode_req == ctmc_pkg::MODE_WAKE;
            next_st.en_cnt = C_ZERO;
            next_st.tx_block = 1'b1;
            next_st.sil_cnt = C_ZERO;
            next_st.wk = WK_IDLE;
        end
        if (rearm_chip && st.mode == ctmc_pkg::MODE_WAKE)
        begin
            next_st.armed = 1'b1;
            next_st.woken = 1'b0;
        end
        // Enable delay, then wait for recessive before driving
        if (st.en_cnt < C_EN)
            next_st.en_cnt = st.en_cnt + C_ONE;
        else if (tx_i)
            next_st.tx_block = 1'b0;
        // Wake pattern detector, Off and others ignore the bus
        if (st.mode != ctmc_pkg::MODE_WAKE || !st.armed)
        begin
            next_st.wk = WK_IDLE;
            next_st.wk_cnt = C_ZERO;
        end
        else
        begin
            next_st.wk_cnt = (st.wk_cnt < C_WMX) ? st.wk_cnt + C_ONE
                : st.wk_cnt;
            unique case (st.wk)
                WK_IDLE:
                    if (!rx_i)
                    begin
                        next_st.wk = WK_DOM1;
                        next_st.wk_cnt = C_ONE;
                    end
                WK_DOM1:
                    if (rx_i)
                    begin
                        next_st.wk = (st.wk_cnt >= C_WMN && st.wk_cnt < C_WMX)
                            ? WK_REC : WK_IDLE;
                        next_st.wk_cnt = C_ONE;
                    end
                WK_REC:
                    if (!rx_i)
                    begin
                        next_st.wk = (st.wk_cnt > C_WMN && st.wk_cnt < C_WMX)
                            ? WK_DOM2 : WK_DOM1;
                        next_st.wk_cnt = C_ONE;
                    end
                    else if (st.wk_cnt >= C_WMX)
                        next_st.wk = WK_IDLE;
                WK_DOM2:
                    if (st.wk_cnt >= C_WMN)
                    begin
                        wake_ev = 1'b1;
                        next_st.wk = WK_IDLE;
                    end
                    else if (rx_i)
                    begin
                        next_st.wk = WK_IDLE;
                        next_st.wk_cnt = C_ZERO;
                    end
            endcase
        end
        if (wake_ev)
        begin
            next_st.woken = 1'b1;
            next_st.armed = 1'b0;
            unique case (chip_mode)
                ctmc_pkg::CHIP_STOP, ctmc_pkg::CHIP_NORMAL:
                begin
                    next_st.irq_n = 1'b0;
                    if (chip_mode == ctmc_pkg::CHIP_STOP
                        && watchdog_on_bus_wake && !watchdog_enabled)
                        next_st.wd_req = 1'b1;
                end
                ctmc_pkg::CHIP_SLEEP, ctmc_pkg::CHIP_FAILSAFE:
                    next_st.rst_req = 1'b1;
                default: ;
            endcase
        end
        // Status flags: set wins over clear
        next_st.wstat = wake_ev || (st.wstat && !wake_clr);
        if (st.irq_n == 1'b0 && wake_clr && !wake_ev)
            next_st.irq_n = 1'b1;
        // Transmit dominant timeout
        if (st.mode == ctmc_pkg::MODE_NORM && !tx_i)
            next_st.tx_cnt = (st.tx_cnt < C_TXT) ? st.tx_cnt + C_ONE
                : st.tx_cnt;
        else
            next_st.tx_cnt = C_ZERO;
        // Bus dominant clamping
        if (uv_on && !rx_i)
            next_st.bus_cnt = (st.bus_cnt < C_BST) ? st.bus_cnt + C_ONE
                : st.bus_cnt;
        else
            next_st.bus_cnt = C_ZERO;
        next_st.fail = st.tx_cnt >= C_TXT || st.bus_cnt >= C_BST
            || (st.fail && !fail_clr);
        next_st.uvf = (uv_on && uv_i) || (st.uvf && !uv_clr);
        // Driver: Normal, enabled, no timeout, supply good
        next_st.drive = st.mode == ctmc_pkg::MODE_NORM && !tx_i
            && !st.tx_block && st.tx_cnt < C_TXT && !uv_i;
        // Receiver
        if (st.mode == ctmc_pkg::MODE_WAKE)
            next_st.rxo = !st.woken;
        else if (st.mode == ctmc_pkg::MODE_OFF)
            next_st.rxo = 1'b1;
        else
            next_st.rxo = rx_i;
        // Termination
        if (st.mode == ctmc_pkg::MODE_WAKE && st.sil_cnt < C_SIL)
            next_st.sil_cnt = st.sil_cnt + C_ONE;
        unique case (st.mode)
            ctmc_pkg::MODE_NORM: next_st.term = ctmc_pkg::TERM_HALF;
            ctmc_pkg::MODE_RXO:
                next_st.term = uv_i ? ctmc_pkg::TERM_2V5 : ctmc_pkg::TERM_HALF;
            ctmc_pkg::MODE_WAKE:
                next_st.term = st.woken ? ctmc_pkg::TERM_2V5
                    : (st.sil_cnt >= C_SIL) ? ctmc_pkg::TERM_GND
                    : ctmc_pkg::TERM_FLOAT;
            ctmc_pkg::MODE_OFF: next_st.term = ctmc_pkg::TERM_FLOAT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st <= '0;
            st.tx_s <= 2'h3;
            st.rx_s <= 2'h3;
            st.mode <= ctmc_pkg::MODE_OFF;
            st.wk <= WK_IDLE;
            st.tx_block <= 1'b1;
            st.rxo <= 1'b1;
            st.irq_n <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign bus_drive_dom = st.drive;
    assign rx_data_out = st.rxo;
    assign interrupt_out_n = st.irq_n;
    assign mode_bits = st.mode;
    assign term_sel = st.term;
    assign wake_status_reg = st.wstat;
    assign transceiver_fail_flag = st.fail;
    assign supply_undervoltage_flag = st.uvf;
    assign watchdog_enable_req = st.wd_req;
    assign chip_restart_req = st.rst_req;

    ////////////////////////////////////////////////////////////////////
    // Checks; the controller side of enabling is assumed, not checked
    property p_off_no_drive;
        @(posedge clk) disable iff (srst)
        st.mode == ctmc_pkg::MODE_OFF |=> !bus_drive_dom;
    endproperty
    a_off_no_drive: assert property (p_off_no_drive)
        else $error("driver active outside Normal");
    property p_norm_chip;
        @(posedge clk) disable iff (srst)
        $changed(mode_bits) && mode_bits == ctmc_pkg::MODE_NORM
            |-> $past(chip_mode) == ctmc_pkg::CHIP_NORMAL;
    endproperty
    a_norm_chip: assert property (p_norm_chip)
        else $error("Normal entered outside chip Normal");
    property p_rxo_nodrive;
        @(posedge clk) disable iff (srst)
        mode_bits == ctmc_pkg::MODE_RXO |=> !bus_drive_dom;
    endproperty
    a_rxo_nodrive: assert property (p_rxo_nodrive)
        else $error("driver active in Receive Only");
    property p_wake_hold;
        @(posedge clk) disable iff (srst)
        st.woken && mode_bits == ctmc_pkg::MODE_WAKE ##1
            mode_bits == ctmc_pkg::MODE_WAKE |-> !rx_data_out;
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("receive output released after wake");
    property p_fs_wake;
        @(posedge clk) disable iff (srst)
        chip_mode == ctmc_pkg::CHIP_FAILSAFE ##1
            chip_mode == ctmc_pkg::CHIP_FAILSAFE
            |-> mode_bits == ctmc_pkg::MODE_WAKE;
    endproperty
    a_fs_wake: assert property (p_fs_wake)
        else $error("Fail-Safe without Wake Capable");
    property p_tx_to;
        @(posedge clk) disable iff (srst)
        st.tx_cnt >= C_TXT |=> transceiver_fail_flag && !bus_drive_dom;
    endproperty
    a_tx_to: assert property (p_tx_to)
        else $error("transmit timeout not handled");
    property p_uv;
        @(posedge clk) disable iff (srst)
        uv_i && mode_bits[1] |=> supply_undervoltage_flag && !bus_drive_dom;
    endproperty
    a_uv: assert property (p_uv)
        else $error("undervoltage not handled");
    property p_uv_off;
        @(posedge clk) disable iff (srst)
        !mode_bits[1] && !supply_undervoltage_flag && !uv_clr
            |=> !supply_undervoltage_flag;
    endproperty
    a_uv_off: assert property (p_uv_off)
        else $error("undervoltage flagged while unmonitored");
    property p_irq;
        @(posedge clk) disable iff (srst)
        wake_ev && (chip_mode == ctmc_pkg::CHIP_SLEEP
            || chip_mode == ctmc_pkg::CHIP_FAILSAFE)
            |=> interrupt_out_n == $past(interrupt_out_n) && chip_restart_req;
    endproperty
    a_irq: assert property (p_irq)
        else $error("sleep wake handled wrongly");
    c_wake: cover property (@(posedge clk) disable iff (srst) wake_ev);
    c_txto: cover property (@(posedge clk) disable iff (srst)
        st.tx_cnt >= C_TXT);
    c_gnd: cover property (@(posedge clk) disable iff (srst)
        term_sel == ctmc_pkg::TERM_GND);
endmodule
`default_nettype wire

//--- dv/ctmc_partner.sv
`default_nettype none
// Controller pins plus a wired bus shared with remote nodes
module ctmc_partner (
    // Clock
    input  wire logic       clk,
    // Device side
    input  wire logic       bus_drive_dom,
    input  wire logic [1:0] mode_bits,
    // Pins
    output logic            tx_data_in,
    output logic            bus_rx
);
    timeunit 1ns;
    timeprecision 1ns;

    logic remote_dom;
    int   en_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Bus reads dominant whenever any node drives it
    assign bus_rx = ~(bus_drive_dom | remote_dom);

    initial
    begin
        tx_data_in = 1'b1;
        remote_dom = 1'b0;
        en_cnt     = 0;
    end

    // Cycles since the transceiver entered Normal
    always @(posedge clk)
    begin
        if (mode_bits !== ctmc_pkg::MODE_NORM)
            en_cnt <= 0;
        else if (en_cnt < ctmc_pkg::ENABLE_CYC)
            en_cnt <= en_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // All tasks start and end just after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    // Early skips the enable wait on purpose, only for refusal checks
    task automatic tx_dom(input int n, input bit early);
        if (!early)
        begin
            while (en_cnt < ctmc_pkg::ENABLE_CYC)
                cyc(1);
        end
        tx_data_in = 1'b0;
        cyc(n);
        tx_data_in = 1'b1;
        cyc(1);
    endtask

    task automatic bus_phase(input logic v, input int n);
        remote_dom = v;
        cyc(n);
    endtask

    // Both dominant and the recessive phase sit inside the window
    task automatic wake();
        bus_phase(1'b1, 10);
        bus_phase(1'b0, 10);
        bus_phase(1'b1, 10);
        bus_phase(1'b0, 1);
    endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, srst, mode_wr, watchdog_on_bus_wake, watchdog_enabled;
    logic       fail_clr, uv_clr, wake_clr, supply_uv, tx_data_in, bus_rx;
    logic       bus_drive_dom, rx_data_out, interrupt_out_n, wake_status_reg;
    logic       transceiver_fail_flag, supply_undervoltage_flag;
    logic       watchdog_enable_req, chip_restart_req;
    logic [1:0] mode_req, mode_bits, term_sel;
    logic [2:0] chip_mode;
    int         errors = 0;
    int         tests_run = 0;
    int         dom_cnt = 0;
    int         rx_cnt = 0;
    int         wd_cnt = 0;
    int         rst_cnt = 0;

    ////////////////////////////////////////////////////////////////////////
    // Short counts keep the run small
    ctmc_core #(
        .TX_TO_CYCLES    (50),
        .BUS_TO_CYCLES   (60),
        .SILENCE_CYCLES  (20),
        .WAKE_MAX_CYCLES (40)
    ) dut (
        .clk                      (clk),
        .srst                     (srst),
        .mode_wr                  (mode_wr),
        .mode_req                 (mode_req),
        .chip_mode                (chip_mode),
        .watchdog_on_bus_wake     (watchdog_on_bus_wake),
        .watchdog_enabled         (watchdog_enabled),
        .fail_clr                 (fail_clr),
        .uv_clr                   (uv_clr),
        .wake_clr                 (wake_clr),
        .tx_data_in               (tx_data_in),
        .bus_rx                   (bus_rx),
        .supply_uv                (supply_uv),
        .bus_drive_dom            (bus_drive_dom),
        .rx_data_out              (rx_data_out),
        .interrupt_out_n          (interrupt_out_n),
        .mode_bits                (mode_bits),
        .term_sel                 (term_sel),
        .wake_status_reg          (wake_status_reg),
        .transceiver_fail_flag    (transceiver_fail_flag),
        .supply_undervoltage_flag (supply_undervoltage_flag),
        .watchdog_enable_req      (watchdog_enable_req),
        .chip_restart_req         (chip_restart_req)
    );

    ctmc_partner ctl (
        .clk           (clk),
        .bus_drive_dom (bus_drive_dom),
        .mode_bits     (mode_bits),
        .tx_data_in    (tx_data_in),
        .bus_rx        (bus_rx)
    );

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // Pulses last one cycle, so they are counted rather than sampled
    always @(posedge clk)
    begin
        if (bus_drive_dom === 1'b1)
            dom_cnt <= dom_cnt + 1;
        if (rx_data_out === 1'b0)
            rx_cnt <= rx_cnt + 1;
        if (watchdog_enable_req === 1'b1)
            wd_cnt <= wd_cnt + 1;
        if (chip_restart_req === 1'b1)
            rst_cnt <= rst_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic set_mode(input logic [1:0] m);
        mode_req = m;
        mode_wr  = 1'b1;
        cyc(1);
        mode_wr  = 1'b0;
        cyc(1);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask

    task automatic done(input string name);
        $display("Test %s finished", name);
    endtask

    // Whole sequence needs about six hundred cycles
    initial
    begin
        #500000;
        errors++;
        summarize();
    end

    initial
    begin
        srst = 1'b1;
        {mode_wr, watchdog_on_bus_wake, watchdog_enabled} = 3'h0;
        {fail_clr, uv_clr, wake_clr, supply_uv} = 4'h0;
        mode_req  = ctmc_pkg::MODE_OFF;
        chip_mode = ctmc_pkg::CHIP_NORMAL;
        cyc(5);
        srst = 1'b0;
        cyc(1);
        check(mode_bits, ctmc_pkg::MODE_OFF);
        check({rx_data_out, interrupt_out_n}, 8'h03);
        check(term_sel, ctmc_pkg::TERM_FLOAT);
        ctl.wake();
        cyc(4);
        check(rx_data_out, 8'h01);
        supply_uv = 1'b1;
        cyc(5);
        check(supply_undervoltage_flag, 8'h00);
        supply_uv = 1'b0;
        done("off");

        chip_mode = ctmc_pkg::CHIP_STOP;
        set_mode(ctmc_pkg::MODE_NORM);
        check(mode_bits, ctmc_pkg::MODE_OFF);
        chip_mode = ctmc_pkg::CHIP_SLEEP;
        set_mode(ctmc_pkg::MODE_RXO);
        check(mode_bits, ctmc_pkg::MODE_OFF);
        chip_mode = ctmc_pkg::CHIP_NORMAL;
        done("refused");

        set_mode(ctmc_pkg::MODE_NORM);
        check(mode_bits, ctmc_pkg::MODE_NORM);
        check(term_sel, ctmc_pkg::TERM_HALF);
        dom_cnt = 0;
        ctl.tx_dom(5, 1'b1);
        cyc(4);
        check(dom_cnt, 8'h00);
        dom_cnt = 0;
        rx_cnt  = 0;
        ctl.tx_dom(10, 1'b0);
        cyc(6);
        check(dom_cnt, 8'h0A);
        check(rx_cnt, 8'h0A);
        done("normal");

        dom_cnt = 0;
        ctl.tx_dom(70, 1'b0);
        cyc(4);
        check(transceiver_fail_flag, 8'h01);
        check(mode_bits, ctmc_pkg::MODE_NORM);
        check(dom_cnt > 45 && dom_cnt < 56, 8'h01);
        pulse(fail_clr);
        check(transceiver_fail_flag, 8'h00);
        dom_cnt = 0;
        ctl.tx_dom(5, 1'b0);
        cyc(4);
        check(dom_cnt, 8'h05);
        ctl.bus_phase(1'b1, 70);
        ctl.bus_phase(1'b0, 4);
        check(transceiver_fail_flag, 8'h01);
        check(mode_bits, ctmc_pkg::MODE_NORM);
        pulse(fail_clr);
        done("timeouts");

        supply_uv = 1'b1;
        cyc(4);
        check(supply_undervoltage_flag, 8'h01);
        dom_cnt = 0;
        ctl.tx_dom(5, 1'b0);
        cyc(4);
        check(dom_cnt, 8'h00);
        supply_uv = 1'b0;
        cyc(4);
        ctl.tx_dom(5, 1'b0);
        cyc(4);
        check(dom_cnt, 8'h05);
        pulse(uv_clr);
        check(supply_undervoltage_flag, 8'h00);
        done("undervoltage");

        set_mode(ctmc_pkg::MODE_RXO);
        check(mode_bits, ctmc_pkg::MODE_RXO);
        dom_cnt = 0;
        rx_cnt  = 0;
        ctl.tx_dom(5, 1'b1);
        ctl.bus_phase(1'b1, 6);
        ctl.bus_phase(1'b0, 4);
        check(dom_cnt, 8'h00);
        check(rx_cnt, 8'h06);
        supply_uv = 1'b1;
        cyc(4);
        check(term_sel, ctmc_pkg::TERM_2V5);
        check(supply_undervoltage_flag, 8'h01);
        supply_uv = 1'b0;
        cyc(3);
        pulse(uv_clr);
        check(supply_undervoltage_flag, 8'h00);
        done("receive only");

        chip_mode = ctmc_pkg::CHIP_STOP;
        watchdog_on_bus_wake = 1'b1;
        set_mode(ctmc_pkg::MODE_WAKE);
        check(mode_bits, ctmc_pkg::MODE_WAKE);
        check(term_sel, ctmc_pkg::TERM_FLOAT);
        cyc(25);
        check(term_sel, ctmc_pkg::TERM_GND);
        ctl.wake();
        cyc(4);
        check({rx_data_out, interrupt_out_n}, 8'h00);
        check(wake_status_reg, 8'h01);
        check(mode_bits, ctmc_pkg::MODE_WAKE);
        check(term_sel, ctmc_pkg::TERM_2V5);
        check(wd_cnt, 8'h01);
        check(rst_cnt, 8'h00);
        ctl.wake();
        cyc(4);
        check(wd_cnt, 8'h01);
        pulse(wake_clr);
        check(interrupt_out_n, 8'h01);
        set_mode(ctmc_pkg::MODE_OFF);
        check(rx_data_out, 8'h01);
        done("stop wake");

        chip_mode = ctmc_pkg::CHIP_FAILSAFE;
        cyc(3);
        check(mode_bits, ctmc_pkg::MODE_WAKE);
        cyc(25);
        ctl.wake();
        cyc(4);
        check(rst_cnt, 8'h01);
        check({rx_data_out, interrupt_out_n}, 8'h01);
        check(wake_status_reg, 8'h01);
        set_mode(ctmc_pkg::MODE_NORM);
        check(mode_bits, ctmc_pkg::MODE_WAKE);
        done("fail-safe wake");
        summarize();
    end
endmodule
`default_nettype wire
